// >>> ext_mem_pkg.sv
package ext_mem_pkg;

  // ==========================================================
  // Interface configuration codes (three-bit field)
  // ==========================================================
  localparam logic [2:0] CFG_MUX_16 = 3'h1;     // Multiplexed, no bank select
  localparam logic [2:0] CFG_MUX_BANK = 3'h2;   // Multiplexed, bank select
  localparam logic [2:0] CFG_MUX_ALT = 3'h3;    // Multiplexed, no bank select
  localparam logic [2:0] CFG_NMUX_16 = 3'h5;    // Non-multiplexed, no bank select
  localparam logic [2:0] CFG_NMUX_BANK = 3'h6;  // Non-multiplexed, bank select
  localparam logic [2:0] CFG_NMUX_ALT = 3'h7;   // Non-multiplexed, no bank select

  // ==========================================================
  // Timing control layout and reset value
  // ==========================================================
  localparam int SETUP_LSB = 6;
  localparam int SETUP_W = 2;
  localparam int WIDTH_LSB = 2;
  localparam int WIDTH_W = 4;
  localparam int HOLD_LSB = 0;
  localparam int HOLD_W = 2;
  localparam logic [7:0] TIMING_RESET = 8'hff;

  // ==========================================================
  // Fixed phase lengths in system clock cycles
  // ==========================================================
  localparam logic [3:0] ADDR_CYC = 4'h2;   // Lead-in before setup
  localparam logic [3:0] TAIL_CYC = 4'h2;   // Tail after hold
  localparam int CLK_PERIOD_NS = 40;
  localparam int CAPTURE_LAG = 3;           // Pin register plus two sync stages

  typedef enum logic [1:0] {
    MODE_NONE,
    MODE_NMUX,
    MODE_MUX
  } bus_mode_e;

  // One external-move request from the core
  typedef struct packed {
    logic [7:0] data_pointer_high;  // Upper address byte
    logic [7:0] data_pointer_low;   // Lower address byte
    logic [7:0] wdata;              // Write data
    logic write;                    // 1 write, 0 read
    logic wide;                     // 1 full 16-bit address, 0 8-bit address
  } move_req_s;

  // One byte-wide port with its drive enable
  typedef struct packed {
    logic [7:0] value;
    logic [7:0] oe;
  } port_drive_s;

endpackage

// >>> move_fifo.sv
`timescale 1ns/100ps
module move_fifo #(
  parameter int WIDTH = 26,
  parameter int DEPTH = 4
) (
  input wire logic clk_i,                // System clock
  input wire logic rst_i,                // Synchronous reset, high
  input wire logic in_valid_i,           // Producer offers a word
  output logic in_ready_o,               // Room for a word
  input wire logic [WIDTH-1:0] in_data_i,  // Word pushed
  output logic out_valid_o,              // A word is waiting
  input wire logic out_ready_i,          // Consumer takes the word
  output logic [WIDTH-1:0] out_data_o    // Oldest word
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] count_q;
  logic push;
  logic pop;

  // Handshakes on both sides
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_valid_o = (count_q != '0);
  assign out_data_o = mem[rd_ptr_q];

  // ==========================================================
  // Storage and pointers
  // ==========================================================
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr_q] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
      end
    end
  end

  // Ready is a flop so the producer never sees a combinational path
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_q <= '0;
      in_ready_o <= 1'b1;
    end else begin
      case ({push, pop})
        2'b10: begin
          count_q <= count_q + 1'b1;
          in_ready_o <= (count_q + 1'b1) != (AW + 1)'(DEPTH);
        end
        2'b01: begin
          count_q <= count_q - 1'b1;
          in_ready_o <= 1'b1;
        end
        default: begin
          count_q <= count_q;
        end
      endcase
    end
  end

endmodule

// >>> ext_mem_bus.sv
// Contract
// R1: Non-multiplexed codes 101, 110, 111 run full 16-bit address moves.
// R2: Non-multiplexed 8-bit moves skip bank select for codes 101 and 111.
// R3: Non-multiplexed 8-bit moves use bank select only for code 110.
// R4: Multiplexed codes 001, 010, 011 run full 16-bit address moves.
// R5: Multiplexed 8-bit moves skip bank select for codes 001 and 011.
// R6: Multiplexed 8-bit moves use bank select only for code 010.
// R7: Non-multiplexed: high address on port 5, low on port 6, data on 7.
// R8: Write strobe on pin 4.7, read strobe on 4.6, unused one idle.
// R9: Address and control lead the strobe by 0 to 3 programmed cycles.
// R10: Strobe stays asserted for 1 to 16 programmed cycles.
// R11: Address and control stay 0 to 3 programmed cycles after strobe.
// R12: Multiplexed: latch strobe high 1 to 4 cycles, then low 1 to 4.
// R13: Write data valid 1 to 19 cycles before the write strobe ends.
// R14: Write data stays driven 0 to 3 cycles after write strobe.
// R15: Upper ports act as bus only during off-chip moves, else GPIO.
// R16: Each access lasts four cycles more than setup plus width plus hold; multiplexed moves also add both latch phases.
// R17: Shortest access is 5 cycles non-multiplexed, 7 multiplexed.
// R18: Setup, width and hold settings reset to their maximum values.
// R19: Multiplexed: low address on data lines while latching, then data.
// R20: Memory drives read data only while the read strobe is low.
`timescale 1ns/100ps
module ext_mem_bus #(
  parameter int FIFO_DEPTH = 4,
  parameter logic [3:0] ALE_HIGH_CYC = 4'h1,  // Latch high time, 1 to 4
  parameter logic [3:0] ALE_LOW_CYC = 4'h1    // Latch low time, 1 to 4
) (
  input wire logic clk_i,                              // System clock
  input wire logic rst_i,                              // Synchronous reset, high
  input wire logic req_valid_i,                        // Core offers a move
  output logic req_ready_o,                            // Move queue has room
  input wire ext_mem_pkg::move_req_s req_i,            // Move request
  input wire logic [2:0] ext_mem_config_field_i,       // Interface configuration
  input wire logic [7:0] ext_mem_timing_ctrl_i,        // Setup, width, hold
  input wire logic [7:0] bank_select_i,                // Upper byte for 8-bit moves
  input wire ext_mem_pkg::port_drive_s gpio_p5_i,      // Port 5 GPIO drive
  input wire ext_mem_pkg::port_drive_s gpio_p6_i,      // Port 6 GPIO drive
  input wire ext_mem_pkg::port_drive_s gpio_p7_i,      // Port 7 GPIO drive
  input wire logic [7:0] p7_i,                         // Port 7 pin level
  output ext_mem_pkg::port_drive_s p5_o,               // Port 5 pins
  output ext_mem_pkg::port_drive_s p6_o,               // Port 6 pins
  output ext_mem_pkg::port_drive_s p7_o,               // Port 7 pins
  output logic wr_strobe_n_o,                          // Pin 4.7, active low
  output logic rd_strobe_n_o,                          // Pin 4.6, active low
  output logic addr_latch_o,                           // Address latch strobe
  output logic [7:0] rdata_o,                          // Captured read data
  output logic rdata_valid_o,                          // Read data pulse
  output logic wr_done_o,                              // Write finished pulse
  output logic cfg_err_o,                              // Move refused, bad code
  output logic busy_o                                  // Bus cycle in progress
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ALE_HI,
    ST_ALE_LO,
    ST_ADDR,
    ST_SETUP,
    ST_STROBE,
    ST_HOLD,
    ST_TAIL
  } bus_state_e;

  // ==========================================================
  // Helpers
  // ==========================================================
  function automatic ext_mem_pkg::bus_mode_e decode_mode(input logic [2:0] code);
    case (code)
      ext_mem_pkg::CFG_NMUX_16, ext_mem_pkg::CFG_NMUX_BANK,
      ext_mem_pkg::CFG_NMUX_ALT: decode_mode = ext_mem_pkg::MODE_NMUX;  // R1
      ext_mem_pkg::CFG_MUX_16, ext_mem_pkg::CFG_MUX_BANK,
      ext_mem_pkg::CFG_MUX_ALT: decode_mode = ext_mem_pkg::MODE_MUX;  // R4
      default: decode_mode = ext_mem_pkg::MODE_NONE;
    endcase
  endfunction

  // Bank select only for the two bank codes
  function automatic logic is_bank_code(input logic [2:0] code);
    is_bank_code = (code == ext_mem_pkg::CFG_NMUX_BANK) ||  // R3
                   (code == ext_mem_pkg::CFG_MUX_BANK);     // R6
  endfunction

  function automatic logic [3:0] field_to_count(input logic [3:0] field);
    field_to_count = (field == 4'h0) ? 4'h0 : field - 4'h1;
  endfunction

  // ==========================================================
  // Move queue
  // ==========================================================
  ext_mem_pkg::move_req_s head;
  logic head_valid;
  logic pop;

  move_fifo #(
    .WIDTH($bits(ext_mem_pkg::move_req_s)),
    .DEPTH(FIFO_DEPTH)
  ) u_queue (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(req_valid_i),
    .in_ready_o(req_ready_o),
    .in_data_i(req_i),
    .out_valid_o(head_valid),
    .out_ready_i(pop),
    .out_data_o(head)
  );

  // ==========================================================
  // Timing settings, set to their maximum by reset
  // ==========================================================
  logic [7:0] timing_q;
  bus_state_e state_q;
  bus_state_e state_d;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;

  // Sampled only while idle so a cycle in flight keeps its figures
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timing_q <= ext_mem_pkg::TIMING_RESET;  // R18
    end else if (state_q == ST_IDLE) begin
      timing_q <= ext_mem_timing_ctrl_i;
    end
  end

  logic [1:0] setup_f;
  logic [3:0] width_f;
  logic [1:0] hold_f;
  assign setup_f = timing_q[ext_mem_pkg::SETUP_LSB +: ext_mem_pkg::SETUP_W];
  assign width_f = timing_q[ext_mem_pkg::WIDTH_LSB +: ext_mem_pkg::WIDTH_W];
  assign hold_f = timing_q[ext_mem_pkg::HOLD_LSB +: ext_mem_pkg::HOLD_W];

  // ==========================================================
  // Current move, latched when taken from the queue
  // ==========================================================
  ext_mem_pkg::move_req_s cur_q;
  ext_mem_pkg::bus_mode_e mode_q;
  logic bank_q;
  ext_mem_pkg::bus_mode_e head_mode;

  assign head_mode = decode_mode(ext_mem_config_field_i);
  assign pop = (state_q == ST_IDLE) && head_valid;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cur_q <= '0;
      mode_q <= ext_mem_pkg::MODE_NONE;
      bank_q <= 1'b0;
    end else if (pop) begin
      cur_q <= head;
      mode_q <= head_mode;
      bank_q <= is_bank_code(ext_mem_config_field_i);  // R2 R5
    end
  end

  // ==========================================================
  // Phase sequencer
  // ==========================================================
  // Lead-in plus tail give the four fixed cycles; zero-length phases are skipped
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      ST_IDLE: begin
        if (head_valid && head_mode == ext_mem_pkg::MODE_MUX) begin
          state_d = ST_ALE_HI;  // R17
          cnt_d = ALE_HIGH_CYC - 4'h1;
        end else if (head_valid && head_mode == ext_mem_pkg::MODE_NMUX) begin
          state_d = ST_ADDR;
          cnt_d = ext_mem_pkg::ADDR_CYC - 4'h1;
        end
      end
      ST_ALE_HI: begin
        if (cnt_q == 4'h0) begin
          state_d = ST_ALE_LO;  // R12
          cnt_d = ALE_LOW_CYC - 4'h1;
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      ST_ALE_LO: begin
        if (cnt_q == 4'h0) begin
          state_d = ST_ADDR;  // R12
          cnt_d = ext_mem_pkg::ADDR_CYC - 4'h1;
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      ST_ADDR: begin
        if (cnt_q != 4'h0) begin
          cnt_d = cnt_q - 4'h1;
        end else if (setup_f != 2'h0) begin
          state_d = ST_SETUP;  // R9
          cnt_d = field_to_count({2'h0, setup_f});
        end else begin
          state_d = ST_STROBE;  // R10
          cnt_d = width_f;
        end
      end
      ST_SETUP: begin
        if (cnt_q == 4'h0) begin
          state_d = ST_STROBE;  // R10
          cnt_d = width_f;
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      ST_STROBE: begin
        if (cnt_q != 4'h0) begin
          cnt_d = cnt_q - 4'h1;
        end else if (hold_f != 2'h0) begin
          state_d = ST_HOLD;  // R11
          cnt_d = field_to_count({2'h0, hold_f});
        end else begin
          state_d = ST_TAIL;  // R16
          cnt_d = ext_mem_pkg::TAIL_CYC - 4'h1;
        end
      end
      ST_HOLD: begin
        if (cnt_q == 4'h0) begin
          state_d = ST_TAIL;  // R16
          cnt_d = ext_mem_pkg::TAIL_CYC - 4'h1;
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      ST_TAIL: begin
        if (cnt_q == 4'h0) begin
          state_d = ST_IDLE;
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      default: begin
        state_d = ST_IDLE;
        cnt_d = 4'h0;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
      cnt_q <= 4'h0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  // ==========================================================
  // Pin drive, registered so every pin comes from a flop
  // ==========================================================
  logic active;
  logic data_phase;
  logic nmux;
  assign active = (state_q != ST_IDLE);
  assign nmux = (mode_q == ext_mem_pkg::MODE_NMUX);
  assign data_phase = (state_q == ST_SETUP) || (state_q == ST_STROBE) ||
                      (state_q == ST_HOLD);

  // Upper address port; 8-bit moves without bank leave it to GPIO
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      p5_o <= '0;
    end else if (active && cur_q.wide) begin
      p5_o <= '{value: cur_q.data_pointer_high, oe: 8'hff};  // R7
    end else if (active && bank_q) begin
      p5_o <= '{value: bank_select_i, oe: 8'hff};  // R3 R6
    end else begin
      p5_o <= gpio_p5_i;  // R15
    end
  end

  // Low address port, used only without multiplexing
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      p6_o <= '0;
    end else if (active && nmux) begin
      p6_o <= '{value: cur_q.data_pointer_low, oe: 8'hff};  // R7
    end else begin
      p6_o <= gpio_p6_i;  // R15
    end
  end

  // Data port: address while latching, write data around the strobe
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      p7_o <= '0;
    end else if (!active) begin
      p7_o <= gpio_p7_i;  // R15
    end else if (state_q == ST_ALE_HI || state_q == ST_ALE_LO) begin
      p7_o <= '{value: cur_q.data_pointer_low, oe: 8'hff};  // R19
    end else if (cur_q.write && data_phase) begin
      p7_o <= '{value: cur_q.wdata, oe: 8'hff};  // R13 R14
    end else begin
      p7_o <= '{value: 8'h00, oe: 8'h00};  // R20
    end
  end

  // Strobes; the one not in use stays high for the whole cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_strobe_n_o <= 1'b1;
      rd_strobe_n_o <= 1'b1;
      addr_latch_o <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      wr_strobe_n_o <= !(state_q == ST_STROBE && cur_q.write);  // R8
      rd_strobe_n_o <= !(state_q == ST_STROBE && !cur_q.write);  // R8
      addr_latch_o <= (state_q == ST_ALE_HI);  // R12
      busy_o <= active || head_valid;
    end
  end

  // ==========================================================
  // Read capture
  // ==========================================================
  // Pin level passes two flops; the flag trails the strobe's last cycle
  // by the pin register plus both sync stages
  logic [7:0] p7_meta_q;
  logic [7:0] p7_sync_q;
  logic [ext_mem_pkg::CAPTURE_LAG-1:0] cap_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      p7_meta_q <= 8'h00;
      p7_sync_q <= 8'h00;
    end else begin
      p7_meta_q <= p7_i;
      p7_sync_q <= p7_meta_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cap_q <= '0;
    end else begin
      cap_q <= {cap_q[ext_mem_pkg::CAPTURE_LAG-2:0],
                state_q == ST_STROBE && cnt_q == 4'h0 && !cur_q.write};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
      rdata_valid_o <= 1'b0;
    end else begin
      rdata_valid_o <= cap_q[ext_mem_pkg::CAPTURE_LAG-1];
      if (cap_q[ext_mem_pkg::CAPTURE_LAG-1]) begin
        rdata_o <= p7_sync_q;  // R20
      end
    end
  end

  // ==========================================================
  // Completion and refusal pulses
  // ==========================================================
  // A move under an unmapped code is dropped without touching the pins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_done_o <= 1'b0;
      cfg_err_o <= 1'b0;
    end else begin
      wr_done_o <= (state_q == ST_TAIL) && (cnt_q == 4'h0) && cur_q.write;
      cfg_err_o <= pop && (head_mode == ext_mem_pkg::MODE_NONE);
    end
  end

endmodule

// >>> ext_mem_checker.sv
`timescale 1ns/100ps
module ext_mem_checker #(
  parameter logic [3:0] ALE_HIGH_CYC = 4'h1
) (
  input wire logic clk_i,                      // System clock
  input wire logic rst_i,                      // Sync reset, high
  input wire ext_mem_pkg::port_drive_s p5_o,   // Port 5 pins
  input wire ext_mem_pkg::port_drive_s p7_o,   // Port 7 pins
  input wire logic wr_strobe_n_o,              // Write strobe
  input wire logic rd_strobe_n_o,              // Read strobe
  input wire logic addr_latch_o,               // Address latch
  input wire logic rdata_valid_o,              // Read data pulse
  input wire logic cfg_err_o,                  // Refused move
  input wire logic busy_o                      // Cycle in progress
);
  logic [4:0] low_q;  // Strobe low run so far
  logic [3:0] ale_q;  // Latch high run so far

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ==========================================================
  // Run-length helpers, saturating so a stuck strobe still fails
  // ==========================================================
  always_ff @(posedge clk_i) begin
    if (rst_i || (wr_strobe_n_o && rd_strobe_n_o)) begin
      low_q <= 5'h00;
    end else if (low_q != 5'h1f) begin
      low_q <= low_q + 5'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !addr_latch_o) begin
      ale_q <= 4'h0;
    end else if (ale_q != 4'hf) begin
      ale_q <= ale_q + 4'h1;
    end
  end

  // ==========================================================
  // Pin relations
  // ==========================================================
  strobe_excl_a: assert property (wr_strobe_n_o || rd_strobe_n_o)
    else $error("both strobes low");
  strobe_max_a: assert property (!(wr_strobe_n_o && rd_strobe_n_o) |-> low_q <= 5'h0f)
    else $error("strobe low too long");
  latch_high_a: assert property ($fell(addr_latch_o) |-> ale_q == ALE_HIGH_CYC)
    else $error("latch high time wrong");
  latch_addr_a: assert property (addr_latch_o |->
    p7_o.oe == 8'hff && wr_strobe_n_o && rd_strobe_n_o)
    else $error("address not on data lines while latching");
  wdata_drive_a: assert property (!wr_strobe_n_o |-> p7_o.oe == 8'hff)
    else $error("write data not driven during strobe");
  wdata_stable_a: assert property (!wr_strobe_n_o && !$past(wr_strobe_n_o) |->
    $stable(p7_o) && $stable(p5_o))
    else $error("address or data moved during write strobe");
  rd_release_a: assert property (!rd_strobe_n_o |-> p7_o.oe == 8'h00)
    else $error("data lines driven during read");
  read_capture_a: assert property ($rose(rd_strobe_n_o) |-> ##2 rdata_valid_o)
    else $error("read data not delivered on time");
  bus_busy_a: assert property (!(wr_strobe_n_o && rd_strobe_n_o) || addr_latch_o |-> busy_o)
    else $error("bus activity while not busy");
  refused_idle_a: assert property (cfg_err_o |->
    wr_strobe_n_o && rd_strobe_n_o && !addr_latch_o)
    else $error("refused move touched the bus");
  reset_idle_a: assert property ($past(rst_i) |->
    wr_strobe_n_o && rd_strobe_n_o && p7_o.oe == 8'h00)
    else $error("bus not idle after reset");
endmodule

bind ext_mem_bus ext_mem_checker #(.ALE_HIGH_CYC(ALE_HIGH_CYC)) chk (
  .clk_i(clk_i), .rst_i(rst_i), .p5_o(p5_o), .p7_o(p7_o), .wr_strobe_n_o(wr_strobe_n_o),
  .rd_strobe_n_o(rd_strobe_n_o), .addr_latch_o(addr_latch_o), .rdata_valid_o(rdata_valid_o),
  .cfg_err_o(cfg_err_o), .busy_o(busy_o)
);

// >>> ext_mem_sram.sv
`timescale 1ns/100ps
module ext_mem_sram (
  input wire logic clk_i,                      // System clock
  input wire logic mux_i,                      // Multiplexed arrangement
  input wire ext_mem_pkg::port_drive_s p5_i,   // Upper address pins
  input wire ext_mem_pkg::port_drive_s p6_i,   // Lower address pins
  input wire ext_mem_pkg::port_drive_s p7_i,   // Data pins, device side
  input wire logic wr_n_i,                     // Write strobe
  input wire logic rd_n_i,                     // Read strobe
  input wire logic latch_i,                    // Address latch
  output logic [7:0] level_o                   // Port 7 wire level
);
  logic [7:0] mem [65536];
  logic [7:0] lo_q;
  logic [7:0] ext;
  logic [15:0] addr;

  // ==========================================================
  // Address decode and wire level
  // ==========================================================
  assign addr = {p5_i.value, mux_i ? lo_q : p6_i.value};

  // Released lines float to the weak pull-up, never to old data
  always_comb begin
    ext = rd_n_i ? 8'hff : mem[addr];
    level_o = (p7_i.value & p7_i.oe) | (ext & ~p7_i.oe);
  end

  // Latch low address, store write data while the strobe is low
  always @(posedge clk_i) begin
    if (latch_i) begin
      lo_q <= level_o;
    end
    if (!wr_n_i) begin
      mem[addr] <= level_o;
    end
  end
endmodule

// >>> external_memory_bus_timing_tb.sv
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module external_memory_bus_timing_tb;
  typedef struct packed {
    logic [2:0] cfg;
    logic [7:0] tim;
    logic wr;
    logic wide;
    logic [15:0] addr;
    logic [7:0] d;
  } row_s;
  localparam ext_mem_pkg::port_drive_s G5 = 16'h1100;  // Idle drive, oe off
  localparam ext_mem_pkg::port_drive_s G6 = 16'h2200;
  localparam ext_mem_pkg::port_drive_s G7 = 16'h3300;
  logic clk_i, rst_i, req_valid, req_ready, wr_n, rd_n, latch, rdata_valid, wr_done, cfg_err, busy;
  logic [2:0] cfg;
  logic [7:0] tim, bank, rdata, level;
  ext_mem_pkg::move_req_s req;
  ext_mem_pkg::port_drive_s p5, p6, p7, p5_s, p6_s, p7_s, exp5;
  int n_mismatch, check_count, len, stb, ale, s, w, h, k;
  bit err_seen, stall;
  row_s rows [12];

  ext_mem_bus #(.FIFO_DEPTH(4), .ALE_HIGH_CYC(4'h1), .ALE_LOW_CYC(4'h1)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .req_valid_i(req_valid), .req_ready_o(req_ready), .req_i(req),
    .ext_mem_config_field_i(cfg), .ext_mem_timing_ctrl_i(tim), .bank_select_i(bank),
    .gpio_p5_i(G5), .gpio_p6_i(G6), .gpio_p7_i(G7), .p7_i(level), .p5_o(p5), .p6_o(p6),
    .p7_o(p7), .wr_strobe_n_o(wr_n), .rd_strobe_n_o(rd_n), .addr_latch_o(latch),
    .rdata_o(rdata), .rdata_valid_o(rdata_valid), .wr_done_o(wr_done), .cfg_err_o(cfg_err),
    .busy_o(busy)
  );

  ext_mem_sram mem (
    .clk_i(clk_i), .mux_i(!cfg[2]), .p5_i(p5), .p6_i(p6), .p7_i(p7), .wr_n_i(wr_n),
    .rd_n_i(rd_n), .latch_i(latch), .level_o(level)
  );

  // ==========================================================
  // Clock, watchdog and pin monitor
  // ==========================================================
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // Longest case is the six slow queued writes, far below this
  initial begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    give_verdict();
  end

  // Upper port drive marks the bus cycle for wide moves
  always @(posedge clk_i) begin
    if (p5.oe == 8'hff) len++;
    if (latch) ale++;
    if (cfg_err) err_seen = 1;
    if (!wr_n || !rd_n) begin
      stb++;
      p5_s = p5;
      p6_s = p6;
      p7_s = p7;
    end
  end

  // ==========================================================
  // Tasks
  // ==========================================================
  task automatic run(input row_s r);
    @(posedge clk_i);
    cfg <= r.cfg;
    tim <= r.tim;
    bank <= r.addr[15:8] ^ 8'hff;
    req <= '{r.addr[15:8], r.addr[7:0], r.d, r.wr, r.wide};
    req_valid <= 1'b1;
    len = 0; stb = 0; ale = 0; err_seen = 0;
    @(posedge clk_i);
    while (req_ready !== 1'b1) @(posedge clk_i);
    req_valid <= 1'b0;
    k = 0;
    while (!(wr_done === 1'b1 || rdata_valid === 1'b1 || cfg_err === 1'b1) && k < 200) begin
      @(posedge clk_i);
      k++;
    end
    `CHK("move_end", 1'b1, k < 200)
    // Let the hold and tail phases finish before reading counts
    repeat (6) @(posedge clk_i);
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    rows = '{'{3'h5, 8'h00, 1, 1, 16'h1234, 8'h5a}, '{3'h5, 8'h00, 0, 1, 16'h1234, 8'h5a},
             '{3'h1, 8'h00, 1, 1, 16'h1235, 8'ha5}, '{3'h1, 8'h00, 0, 1, 16'h1235, 8'ha5},
             '{3'h6, 8'h55, 1, 0, 16'h9940, 8'h3c}, '{3'h6, 8'h55, 0, 0, 16'h9940, 8'h3c},
             '{3'h2, 8'hc6, 1, 0, 16'h7741, 8'h69}, '{3'h2, 8'hc6, 0, 0, 16'h7741, 8'h69},
             '{3'h3, 8'hff, 1, 1, 16'hab42, 8'h96}, '{3'h3, 8'h3c, 0, 1, 16'hab42, 8'h96},
             '{3'h7, 8'h81, 1, 0, 16'h5543, 8'h0f}, '{3'h7, 8'h81, 0, 0, 16'h5543, 8'h0f}};
    rst_i = 1'b1; req_valid = 1'b0; req = '0; cfg = 3'h5; tim = 8'h00; bank = 8'h00;
    n_mismatch = 0; check_count = 0;
    repeat (4) @(posedge clk_i);
    `CHK("reset_ready", 1'b1, req_ready)
    `CHK("reset_wr_n", 1'b1, wr_n)
    `CHK("reset_p7_oe", 8'h00, p7.oe)
    $display("reset done");
    rst_i <= 1'b0;
    // Table rows cover every mapped code, both address widths, both directions
    foreach (rows[i]) begin
      run(rows[i]);
      s = rows[i].tim[7:6];
      w = rows[i].tim[5:2] + 1;
      h = rows[i].tim[1:0];
      exp5 = rows[i].wide ? {rows[i].addr[15:8], 8'hff} :
             (rows[i].cfg[1:0] == 2'h2) ? {rows[i].addr[15:8] ^ 8'hff, 8'hff} : G5;
      `CHK("strobe_cycles", w, stb)
      if (rows[i].wide) `CHK("access_len", 4 + s + w + h + (rows[i].cfg[2] ? 0 : 2), len)
      `CHK("latch_cycles", rows[i].cfg[2] ? 0 : 1, ale)
      `CHK("port5", exp5, p5_s)
      `CHK("port6", rows[i].cfg[2] ? {rows[i].addr[7:0], 8'hff} : G6, p6_s)
      if (rows[i].wr) `CHK("wdata_pins", {rows[i].d, 8'hff}, p7_s)
      else `CHK("rdata", rows[i].d, rdata)
      $display("row %0d done", i);
    end
    `CHK("idle_p7", G7, p7)
    // Undefined codes are dropped without a strobe
    for (int c = 0; c < 8; c += 4) begin
      run('{c[2:0], 8'h00, 1, 1, 16'h1234, 8'hee});
      `CHK("cfg_err", 1'b1, err_seen)
      `CHK("refused_strobes", 0, stb)
    end
    run(rows[1]);
    `CHK("rdata_kept", 8'h5a, rdata)
    $display("refused codes done");
    // Slow moves back to back fill the queue and stall the producer
    @(posedge clk_i);
    cfg <= 3'h5;
    tim <= 8'hff;
    stall = 0;
    for (int i = 0; i < 6; i++) begin
      req <= '{8'h20, 8'h10, 8'h10 + 8'(i), 1'b1, 1'b1};
      req_valid <= 1'b1;
      @(posedge clk_i);
      while (req_ready !== 1'b1) begin
        stall = 1;
        @(posedge clk_i);
      end
    end
    req_valid <= 1'b0;
    k = 0;
    while (busy !== 1'b0 && k < 400) begin
      @(posedge clk_i);
      k++;
    end
    repeat (4) @(posedge clk_i);
    `CHK("queue_drain", 1'b1, k < 400)
    `CHK("queue_stall", 1'b1, stall)
    run('{3'h5, 8'h00, 0, 1, 16'h2010, 8'h15});
    `CHK("queue_order", 8'h15, rdata)
    $display("queue fill done");
    give_verdict();
  end
endmodule
